// >>> sfws_defines.vh
/*
 Shared constants for the flash wake/signature and power-up gating block.
 Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef SFWS_DEFINES_VH
`define SFWS_DEFINES_VH

// -----------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------
`define SFWS_CMD_WAKE_SIG 8'hAB
`define SFWS_CMD_WRITE_EN 8'h06
`define SFWS_CMD_PAGE_WR 8'h02
`define SFWS_CMD_SECT_WIPE 8'hD8
`define SFWS_CMD_CHIP_WIPE 8'hC7
`define SFWS_CMD_STAT_WR 8'h01
`define SFWS_CMD_SLEEP 8'hB9

// -----------------------------------------------------------------
// Serial framing
// -----------------------------------------------------------------
`define SFWS_BIT_CNT_W 5
`define SFWS_CMD_LAST_BIT 5'h0_7
`define SFWS_DUMMY_LAST_BIT 5'h17
`define SFWS_SIG_LAST_BIT 3'h7
`define SFWS_SIG_MSB 7

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define SFWS_STATUS_RESET 8'h0_0
`define SFWS_ARRAY_ERASED 8'hF_F

// -----------------------------------------------------------------
// Timing: clock rate and delays, in their own units
// -----------------------------------------------------------------
`define SFWS_CLK_KHZ 25000
`define SFWS_PUW_MIN_MS 1
`define SFWS_SHORT_WAKE_US 3
`define SFWS_LONG_WAKE_US 30
`define SFWS_DLY_W 24

`endif

// >>> sfws_sync3.v
/*
 Three-flop input synchroniser with agreement filter.
 Assumes the input comes from outside ref_clk's domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sfws_sync3 #(
  parameter RST_VAL = 1'b0
) (
  input wire ref_clk,
  input wire rst,
  input wire din,
  output reg dout
);

  reg s1;
  reg s2;
  reg s3;

  // -----------------------------------------------------------------
  // Chain; first stage is read only by the second
  // -----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) // Change counts once two stages agree
        dout <= s3;
    end
  end

endmodule

`default_nettype wire

// >>> sfws_flash_wake.v
/*
 Flash SPI front end: wake-and-signature command, deep power-down
 tracking, and power-up write inhibit gating.
 Assumes rst is driven by the power-on detector (high while the supply
 is under the write-inhibit threshold), and that SPI pins come straight
 from the host, far slower than ref_clk (mode 0 or 3).
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfws_defines.vh"

module sfws_flash_wake #(
  parameter [7:0] WAKE_OPCODE = `SFWS_CMD_WAKE_SIG,
  parameter [7:0] SIGNATURE = 8'h5_A, // Arbitrary identity value
  parameter integer SHORT_WAKE_US = `SFWS_SHORT_WAKE_US,
  parameter integer LONG_WAKE_US = `SFWS_LONG_WAKE_US,
  parameter integer PUW_CYCLES = `SFWS_PUW_MIN_MS * `SFWS_CLK_KHZ
) (
  input wire ref_clk,
  input wire rst,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  input wire cycle_busy_flag,
  input wire cycle_done,
  output reg deep_sleep,
  output reg waking,
  output reg write_latch_flag,
  output reg write_cmd_pulse,
  output reg [7:0] write_cmd_code,
  output reg powerup_write_ok,
  output reg [7:0] status_init,
  output reg [7:0] array_fill
);

  // Wake delays in cycles; longest-time style rounding down, at least one
  localparam integer SHORT_RAW = (SHORT_WAKE_US * `SFWS_CLK_KHZ) / 1000;
  localparam integer LONG_RAW = (LONG_WAKE_US * `SFWS_CLK_KHZ) / 1000;
  localparam integer SHORT_CYC = (SHORT_RAW < 1) ? 1 : SHORT_RAW;
  localparam integer LONG_CYC = (LONG_RAW < 1) ? 1 : LONG_RAW;
  localparam [`SFWS_DLY_W-1:0] SHORT_CNT = SHORT_CYC[`SFWS_DLY_W-1:0];
  localparam [`SFWS_DLY_W-1:0] LONG_CNT = LONG_CYC[`SFWS_DLY_W-1:0];
  localparam [`SFWS_DLY_W-1:0] PUW_CNT = PUW_CYCLES[`SFWS_DLY_W-1:0];

  // Frame states, one-hot
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CMD = 5'b00010;
  localparam [4:0] ST_DUMMY = 5'b00100;
  localparam [4:0] ST_SIG = 5'b01000;
  localparam [4:0] ST_SKIP = 5'b10000;

  wire cs_n_s;
  wire sck_s;
  wire mosi_s;
  reg sck_d;
  reg cs_d;
  reg [4:0] state;
  reg [`SFWS_BIT_CNT_W-1:0] bit_cnt;
  reg [7:0] cmd_sr;
  reg [2:0] sig_idx;
  reg sig_once;
  reg wake_seen;
  reg [`SFWS_DLY_W-1:0] wake_cnt;
  reg [`SFWS_DLY_W-1:0] puw_cnt;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [7:0] next_cmd;
  wire is_write_code;

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  sfws_sync3 #(.RST_VAL(1'b1)) u_cs (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(spi_cs_n),
    .dout(cs_n_s)
  );
  sfws_sync3 #(.RST_VAL(1'b0)) u_sck (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(spi_sck),
    .dout(sck_s)
  );
  sfws_sync3 #(.RST_VAL(1'b0)) u_mosi (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(spi_mosi),
    .dout(mosi_s)
  );

  // Edge finders on filtered levels
  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d;
  assign next_cmd = {cmd_sr[6:0], mosi_s};
  assign is_write_code = (next_cmd == `SFWS_CMD_WRITE_EN) ||
                         (next_cmd == `SFWS_CMD_PAGE_WR) ||
                         (next_cmd == `SFWS_CMD_SECT_WIPE) ||
                         (next_cmd == `SFWS_CMD_CHIP_WIPE) ||
                         (next_cmd == `SFWS_CMD_STAT_WR);

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sck_d <= sck_s;
      cs_d <= cs_n_s;
    end
  end

  // -----------------------------------------------------------------
  // Power-up write delay counter
  // -----------------------------------------------------------------
  // Reset held by the power-on detector keeps everything idle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      puw_cnt <= {`SFWS_DLY_W{1'b0}};
      powerup_write_ok <= 1'b0;
    end
    else if (puw_cnt == PUW_CNT)
      powerup_write_ok <= 1'b1;
    else
      puw_cnt <= puw_cnt + 1'b1;
  end

  // -----------------------------------------------------------------
  // Command frame machine
  // -----------------------------------------------------------------
  // Decode on the rising edge; busy cycles suppress the wake decode
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= {`SFWS_BIT_CNT_W{1'b0}};
      cmd_sr <= 8'h0_0;
      wake_seen <= 1'b0;
      sig_once <= 1'b0;
      write_cmd_pulse <= 1'b0;
      write_cmd_code <= 8'h0_0;
    end
    else
    begin
      write_cmd_pulse <= 1'b0;
      if (cs_n_s)
      begin
        state <= ST_IDLE;
        bit_cnt <= {`SFWS_BIT_CNT_W{1'b0}};
        if (!cs_d)
        begin
          cmd_sr <= 8'h0_0; // A bare select must not replay an old opcode
          wake_seen <= 1'b0;
          sig_once <= 1'b0;
        end
      end
      else if (state == ST_IDLE)
      begin
        state <= ST_CMD;
        bit_cnt <= {`SFWS_BIT_CNT_W{1'b0}};
      end
      else if (sck_rise)
      begin
        case (state)
          ST_CMD:
          begin
            cmd_sr <= next_cmd;
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `SFWS_CMD_LAST_BIT)
            begin
              bit_cnt <= {`SFWS_BIT_CNT_W{1'b0}};
              if (next_cmd == WAKE_OPCODE && !cycle_busy_flag)
              begin
                wake_seen <= 1'b1;
                state <= ST_DUMMY;
              end
              else
              begin
                state <= ST_SKIP; // Rest of frame ignored until deselect
                // Asleep: other commands are not decoded
                if (!deep_sleep && is_write_code && powerup_write_ok)
                begin
                  write_cmd_pulse <= 1'b1;
                  write_cmd_code <= next_cmd;
                end
              end
            end
          end
          ST_DUMMY:
          begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `SFWS_DUMMY_LAST_BIT)
              state <= ST_SIG;
          end
          ST_SIG:
          begin
            if (sig_idx == 3'h0)
              sig_once <= 1'b1; // Last bit sampled by host
          end
          default:
            state <= state;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Signature shifter
  // -----------------------------------------------------------------
  // First bit shown with the fall ending the last dummy bit; later bits on falls
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sig_idx <= `SFWS_SIG_LAST_BIT;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else if (state != ST_SIG || cs_n_s)
    begin
      sig_idx <= `SFWS_SIG_LAST_BIT;
      spi_miso <= SIGNATURE[`SFWS_SIG_MSB];
      spi_miso_oe <= 1'b0;
    end
    else
    begin
      // That first fall only arms the output, else bit 7 would be skipped
      if (sck_fall)
      begin
        spi_miso_oe <= 1'b1;
        if (spi_miso_oe)
        begin
          sig_idx <= sig_idx - 1'b1; // Wraps 0 to 7: byte repeats
          spi_miso <= SIGNATURE[sig_idx - 1'b1];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Sleep, wake delay and write latch
  // -----------------------------------------------------------------
  // Sleep entry from the sleep opcode is kept here for completeness
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      deep_sleep <= 1'b0;
      waking <= 1'b0;
      wake_cnt <= {`SFWS_DLY_W{1'b0}};
      write_latch_flag <= 1'b0;
    end
    else
    begin
      if (cs_rise && wake_seen && deep_sleep)
      begin
        waking <= 1'b1;
        wake_cnt <= sig_once ? LONG_CNT : SHORT_CNT;
      end
      else if (waking)
      begin
        if (wake_cnt == {{(`SFWS_DLY_W-1){1'b0}}, 1'b1})
        begin
          waking <= 1'b0;
          deep_sleep <= 1'b0;
        end
        wake_cnt <= wake_cnt - 1'b1;
      end
      else if (cs_rise && cmd_sr == `SFWS_CMD_SLEEP && !cycle_busy_flag
               && !wake_seen)
        deep_sleep <= 1'b1;
      // Set wins over the clear from a finished cycle
      if (write_cmd_pulse && write_cmd_code == `SFWS_CMD_WRITE_EN)
        write_latch_flag <= 1'b1;
      else if (cycle_done)
        write_latch_flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Fresh-state values for the array and status models
  // -----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    status_init <= `SFWS_STATUS_RESET;
    array_fill <= `SFWS_ARRAY_ERASED;
  end

endmodule

`default_nettype wire

// >>> sfws_host.sv
/* SPI host model (mode 0) for the flash front end.
   Assumes ref_clk at 25 MHz; sck half period is 4 ref_clk cycles. */
`timescale 1ns/1ps
`default_nettype none
module sfws_host (
  input wire logic ref_clk,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic last_q = 1'b0;
  // Released line shows the inverse, never a stale value
  wire q = spi_miso_oe ? spi_miso : ~last_q;
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // One frame, MSB first; read just before each fall
  task automatic frame(input logic [47:0] tx, input int n, input int hold,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge ref_clk) spi_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_mosi <= tx[i];
      repeat (4) @(posedge ref_clk);
      spi_sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rx = {rx[14:0], q};
      last_q = q;
      spi_sck <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    repeat (hold) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> sfws_flash_wake_props.sv
/* Port checker for the flash wake block.
   Assumes the bind below and a 25 MHz ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module sfws_props #(
  parameter int LONG_WAKE_US = 30,
  parameter int PUW_CYCLES = 25000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic cycle_busy_flag,
  input wire logic deep_sleep,
  input wire logic waking,
  input wire logic write_latch_flag,
  input wire logic write_cmd_pulse,
  input wire logic [7:0] write_cmd_code,
  input wire logic powerup_write_ok,
  input wire logic [7:0] status_init,
  input wire logic [7:0] array_fill
);
  // Slack covers the pin synchronisers
  localparam int WAKE_MAX = LONG_WAKE_US * 25 + 20;
  int since_rst;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Cycles since reset, saturating; a counter instead of a very deep $past
  always @(posedge ref_clk)
  begin
    if (rst)
      since_rst <= 0;
    else if (since_rst < PUW_CYCLES + 4)
      since_rst <= since_rst + 1;
  end
  AST_RST_IDLE: assert property (disable iff (1'b0)
    rst |=> !spi_miso_oe && !deep_sleep && !waking && !write_latch_flag
    && !write_cmd_pulse && !powerup_write_ok) else $error("reset state wrong");
  AST_FRESH: assert property (
    status_init == 8'h00 && array_fill == 8'hFF) else $error("fresh values wrong");
  AST_PUW_EARLY: assert property (
    $rose(powerup_write_ok) |-> since_rst >= PUW_CYCLES) else $error("write ok early");
  AST_PUW_DUE: assert property (
    since_rst >= PUW_CYCLES + 3 |-> powerup_write_ok) else $error("write ok late");
  AST_WRITE_GATE: assert property (
    write_cmd_pulse |-> powerup_write_ok && !deep_sleep) else $error("write taken");
  AST_LATCH_SRC: assert property (
    $rose(write_latch_flag) |-> write_cmd_code == 8'h06) else $error("latch cause");
  AST_BUSY_IGNORE: assert property (
    $rose(spi_miso_oe) |-> !$past(cycle_busy_flag)) else $error("answered busy");
  AST_FALL_SHIFT: assert property (
    spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |-> !$past(spi_sck, 2))
    else $error("miso moved off fall");
  AST_WAKE_SLEEP: assert property (
    waking |-> deep_sleep) else $error("waking while awake");
  AST_WAKE_BOUND: assert property (
    $rose(waking) |-> ##[1:WAKE_MAX] !waking) else $error("wake too long");
  AST_STANDBY: assert property (
    $fell(waking) |-> !deep_sleep) else $error("no standby");
endmodule
bind sfws_flash_wake sfws_props #(.LONG_WAKE_US(LONG_WAKE_US), .PUW_CYCLES(PUW_CYCLES))
  u_props (.ref_clk, .rst, .spi_sck, .spi_miso, .spi_miso_oe, .cycle_busy_flag,
  .deep_sleep, .waking, .write_latch_flag, .write_cmd_pulse, .write_cmd_code,
  .powerup_write_ok, .status_init, .array_fill);
`default_nettype wire

// >>> sfws_flash_wake_tb_top.sv
/* Self-checking bench for the flash wake block.
   Assumes sfws_host as SPI partner and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module sfws_flash_wake_tb_top;
  localparam int PUW = 800;
  // Select delay of 10 us at 40 ns per cycle, with a little margin
  localparam int VSL = 260;
  localparam logic [47:0] WAKE = 48'hAB00_0000_0000;
  localparam logic [15:0] SIG2 = 16'h5A5A;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cycle_busy_flag = 1'b0;
  logic cycle_done = 1'b0;
  wire spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  wire deep_sleep, waking, write_latch_flag, write_cmd_pulse, powerup_write_ok;
  wire [7:0] write_cmd_code, status_init, array_fill;
  logic [15:0] rx;
  int bad_count = 0;
  int checks = 0;
  always #20 ref_clk = ~ref_clk;
  sfws_flash_wake #(.SIGNATURE(8'h5A), .PUW_CYCLES(PUW)) u_dut (.ref_clk, .rst,
    .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe, .cycle_busy_flag,
    .cycle_done, .deep_sleep, .waking, .write_latch_flag, .write_cmd_pulse,
    .write_cmd_code, .powerup_write_ok, .status_init, .array_fill);
  sfws_host u_host (.ref_clk, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso,
    .spi_miso_oe);
  task automatic cmp(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Watchdog: run needs about 4k cycles, limit is 60k
  initial
  begin
    #2400000;
    bad_count++;
    final_report();
  end
  // Main sequence
  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(1);
    cmp("status_init", status_init, 16'h0000);
    cmp("array_fill", array_fill, 16'h00FF);
    cmp("deep_sleep", deep_sleep, 16'h0000);
    cmp("power-up latch", write_latch_flag, 16'h0000);
    cmp("power-up waking", waking, 16'h0000);
    tick(VSL);
    // A write sent before the write delay must be dropped
    u_host.frame(48'h06, 8, 10, rx);
    cmp("early latch", write_latch_flag, 16'h0000);
    cmp("early code", write_cmd_code, 16'h0000);
    cmp("early write ok", powerup_write_ok, 16'h0000);
    // Reads are allowed before the write delay ends
    u_host.frame(WAKE, 48, 10, rx);
    cmp("sig awake", rx, SIG2);
    cmp("waking awake", waking, 16'h0000);
    cmp("awake stays", deep_sleep, 16'h0000);
    cmp("read before ok", powerup_write_ok, 16'h0000);
    tick(PUW);
    cmp("write ok", powerup_write_ok, 16'h0001);
    u_host.frame(48'h06, 8, 10, rx);
    cmp("latch", write_latch_flag, 16'h0001);
    cmp("code", write_cmd_code, 16'h0006);
    cycle_done <= 1'b1;
    tick(1);
    cycle_done <= 1'b0;
    tick(3);
    cmp("latch clear", write_latch_flag, 16'h0000);
    u_host.frame(48'hB9, 8, 10, rx);
    cmp("asleep", deep_sleep, 16'h0001);
    cycle_busy_flag <= 1'b1;
    u_host.frame(WAKE, 48, 10, rx);
    cycle_busy_flag <= 1'b0;
    cmp("busy ignored", deep_sleep, 16'h0001);
    cmp("busy no wake", waking, 16'h0000);
    u_host.frame(WAKE, 48, 10, rx);
    cmp("sig asleep", rx, SIG2);
    cmp("long waking", waking, 16'h0001);
    tick(690);
    cmp("long still", deep_sleep, 16'h0001);
    tick(80);
    cmp("long done", deep_sleep, 16'h0000);
    cmp("long over", waking, 16'h0000);
    u_host.frame(48'hB9, 8, 10, rx);
    u_host.frame(48'hAB, 8, 10, rx);
    cmp("short waking", waking, 16'h0001);
    tick(90);
    cmp("short done", deep_sleep, 16'h0000);
    u_host.frame(48'h06, 8, 10, rx);
    cmp("latch again", write_latch_flag, 16'h0001);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    cmp("reset latch", write_latch_flag, 16'h0000);
    cmp("reset ok", powerup_write_ok, 16'h0000);
    cmp("reset sleep", deep_sleep, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
